// ==== crc_board.sv ====
// Board model: reset button with pull-down, and the analog VCO stand-in.
// Assumes the pump outputs steer the VCO period while the PLL runs.
`timescale 1ns/1ps
module crc_board (
  // Controls
  input  wire logic press,
  input  wire logic run,
  input  wire logic up,
  input  wire logic dn,
  // Pins
  output logic      rst_pin,
  output logic      vco
);
  // Pull-down holds the pin low once the button is let go
  assign rst_pin = press;
  initial vco = 1'b0;
  // Pump nudges the half period so the loop can settle.
  // Each level must span at least two clk_sys samples, or the pin filter drops it.
  always begin
    if (run) begin
      #(up ? 32 : (dn ? 48 : 40));
      vco = ~vco;
    end else begin
      vco = 1'b0;
      #5;
    end
  end
endmodule : crc_board

// ==== crc_pfd.sv ====
// Phase-frequency comparator with lock detector, digital model.
// Assumes ref_tick and fb_tick are one-cycle pulses on clk_sys.
`timescale 1ns/1ps
module crc_pfd (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Divided clocks in, pump pulses and lock out
  crc_pll_if.pfd    pll
);

  // ==========================================================================
  // Up/down pulse pair
  logic                       up_r;
  logic                       down_r;
  logic [crc_pkg::ERR_W-1:0]  err_cnt_r;
  logic [crc_pkg::LOCK_W-1:0] lock_cnt_r;

  wire up_seen   = up_r | pll.ref_tick;
  wire down_seen = down_r | pll.fb_tick;
  wire both_seen = up_seen & down_seen;
  wire err_sat   = (err_cnt_r == {crc_pkg::ERR_W{1'b1}});
  wire in_window = (err_cnt_r <= crc_pkg::LOCK_WIN_CYCLES);
  wire lock_full = (lock_cnt_r == crc_pkg::LOCK_CONFIRM);

  // Up while reference leads, down while feedback leads; both seen clears both
  wire up_nxt   = pll.enable & up_seen & ~both_seen;
  wire down_nxt = pll.enable & down_seen & ~both_seen;

  wire [crc_pkg::ERR_W-1:0] err_nxt =
    (!pll.enable || both_seen) ? '0 :
    ((up_r | down_r) && !err_sat) ? err_cnt_r + 1'b1 : err_cnt_r;

  // Lock needs a run of close edge pairs; one wide pair restarts it
  wire [crc_pkg::LOCK_W-1:0] lock_nxt =
    !pll.enable ? '0 :
    !both_seen ? lock_cnt_r :
    !in_window ? '0 :
    lock_full ? lock_cnt_r : lock_cnt_r + 1'b1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      up_r       <= 1'b0;
      down_r     <= 1'b0;
      err_cnt_r  <= '0;
      lock_cnt_r <= '0;
    end else begin
      up_r       <= up_nxt;
      down_r     <= down_nxt;
      err_cnt_r  <= err_nxt;
      lock_cnt_r <= lock_nxt;
    end
  end

  assign pll.up     = up_r;
  assign pll.down   = down_r;
  assign pll.locked = lock_full;

endmodule : crc_pfd

// ==== crc_pkg.sv ====
// Constants and types shared by the clock and reset controller files.
// Assumes a single oscillator clock drives all logic.
package crc_pkg;

  // ==========================================================================
  // Reset qualifier
  localparam int unsigned        RST_QUAL_PERIODS = 64;
  localparam int unsigned        RST_CNT_W        = 7;
  localparam logic [RST_CNT_W-1:0] RST_CNT_DONE   = RST_CNT_W'(RST_QUAL_PERIODS);
  localparam int unsigned        SYNC_STAGES      = 3;

  // ==========================================================================
  // PLL dividers and lock detector
  localparam int unsigned        DIV_W            = 8;
  localparam int unsigned        ERR_W            = 8;
  localparam int unsigned        LOCK_W           = 5;
  localparam logic [ERR_W-1:0]   LOCK_WIN_CYCLES  = 8'h02;
  localparam logic [LOCK_W-1:0]  LOCK_CONFIRM     = 5'h10;

  // ==========================================================================
  // Clock consumers
  localparam int unsigned        NUM_PER          = 5;
  localparam int unsigned        PER_TIMER0       = 0;
  localparam int unsigned        PER_TIMER1       = 1;
  localparam int unsigned        PER_CARD         = 2;
  localparam int unsigned        PER_SPI          = 3;
  localparam int unsigned        PER_PORT_SAMPLE  = 4;
  localparam int unsigned        NUM_PLL_OUT      = 3;
  localparam int unsigned        PLL_DECODER      = 0;
  localparam int unsigned        PLL_AUDIO        = 1;
  localparam int unsigned        PLL_USB          = 2;

  // ==========================================================================
  // Power state
  typedef enum logic [3:0] {
    CRC_ST_RESET = 4'h1,
    CRC_ST_RUN   = 4'h2,
    CRC_ST_IDLE  = 4'h4,
    CRC_ST_PDOWN = 4'h8
  } crc_pwr_state_t;

endpackage : crc_pkg

// ==== crc_pll_if.sv ====
// Signals between the controller top and its phase comparator / lock detector.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface crc_pll_if;
  logic ref_tick;
  logic fb_tick;
  logic enable;
  logic up;
  logic down;
  logic locked;

  modport top (output ref_tick, output fb_tick, output enable, input up, input down, input locked);
  modport pfd (input ref_tick, input fb_tick, input enable, output up, output down, output locked);
endinterface : crc_pll_if

// ==== crc_top.sv ====
// Clock and reset controller: reset qualifier, power-mode clock gating,
// PLL reference/feedback dividers and gated PLL clock enables.
// Assumes clk_sys is the oscillator clock; analog VCO and pump are outside.
//
// Function
// - Reset after 64 continuous high oscillator periods
// - Force ports to reset while reset applied
// - Reset input wakes chip from idle, power-down
// - All internal clocks generated here
// - Oscillator gives PLL, CPU, peripheral clocks
// - Each clock gated per power mode; pll_tick follows only run enable and lock, not the power mode
// - Peripheral clock feeds timers, card, SPI, ports
// - PLL clock feeds decoder, audio, USB
// - Compare N reference against R feedback
// - PLL output only while run enable set
`timescale 1ns/1ps
module crc_top #(
  parameter int unsigned DIV_W = crc_pkg::DIV_W
) (
  // Clock and power-on reset
  input  wire logic                            clk_sys,
  input  wire logic                            reset_n,
  // Board pins
  input  wire logic                            rst_pin_in,
  input  wire logic                            test_mode_input,
  // Power control from the core
  input  wire logic                            idle_req,
  input  wire logic                            pdown_req,
  input  wire logic                            wake_event,
  input  wire logic [crc_pkg::NUM_PER-1:0]     per_consumer_on,
  // PLL control
  input  wire logic                            pll_run_enable,
  input  wire logic [DIV_W-1:0]                pll_n_div,
  input  wire logic [DIV_W-1:0]                pll_r_div,
  // Analog PLL macro
  input  wire logic                            vco_clk_in,
  output logic                                 charge_up,
  output logic                                 charge_down,
  // Reset outputs
  output logic                                 chip_reset_n_out,
  output logic                                 port_reset_force,
  output logic                                 test_mode_active,
  // Clock enables and PLL lock status
  output logic                                 pll_ref_clk_en,
  output logic                                 cpu_clk_en,
  output logic                                 per_clk_en,
  output logic [crc_pkg::NUM_PER-1:0]          per_tick,
  output logic [crc_pkg::NUM_PLL_OUT-1:0]      pll_tick,
  output logic                                 pll_locked
);

  // ==========================================================================
  // Pin synchronisers
  logic [crc_pkg::SYNC_STAGES-1:0] rst_sync_r;
  logic [crc_pkg::SYNC_STAGES-1:0] tst_sync_r;
  logic [crc_pkg::SYNC_STAGES-1:0] vco_sync_r;
  logic                            rst_level_r;
  logic                            tst_level_r;
  logic                            vco_level_r;

  // A change counts only once stages two and three agree
  wire rst_agree = (rst_sync_r[1] == rst_sync_r[2]);
  wire tst_agree = (tst_sync_r[1] == tst_sync_r[2]);
  wire vco_agree = (vco_sync_r[1] == vco_sync_r[2]);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= '0;
      tst_sync_r <= '1;
      vco_sync_r <= '0;
    end else begin
      rst_sync_r <= {rst_sync_r[1:0], rst_pin_in};
      tst_sync_r <= {tst_sync_r[1:0], test_mode_input};
      vco_sync_r <= {vco_sync_r[1:0], vco_clk_in};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_level_r <= 1'b0;
      tst_level_r <= 1'b1;
      vco_level_r <= 1'b0;
    end else begin
      rst_level_r <= rst_agree ? rst_sync_r[2] : rst_level_r;
      tst_level_r <= tst_agree ? tst_sync_r[2] : tst_level_r;
      vco_level_r <= vco_agree ? vco_sync_r[2] : vco_level_r;
    end
  end

  // ==========================================================================
  // Reset qualifier
  logic [crc_pkg::RST_CNT_W-1:0] rst_cnt_r;
  logic                          chip_reset_r;

  wire rst_qualified = (rst_cnt_r == crc_pkg::RST_CNT_DONE);
  // Any drop before the count completes starts it over
  wire [crc_pkg::RST_CNT_W-1:0] rst_cnt_nxt =
    !rst_level_r ? '0 :
    rst_qualified ? rst_cnt_r : rst_cnt_r + 1'b1;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_r    <= '0;
      chip_reset_r <= 1'b1;
    end else begin
      rst_cnt_r    <= rst_cnt_nxt;
      chip_reset_r <= rst_qualified;
    end
  end

  assign chip_reset_n_out = ~chip_reset_r;
  // Raw pin path so ports are forced even with the oscillator stopped
  assign port_reset_force = rst_pin_in | chip_reset_r;
  // Pin must sit high in normal use; low selects test mode
  assign test_mode_active = ~tst_level_r;

  // ==========================================================================
  // Power state machine
  crc_pkg::crc_pwr_state_t state_r;
  crc_pkg::crc_pwr_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      crc_pkg::CRC_ST_RESET: begin
        if (!chip_reset_r) state_nxt = crc_pkg::CRC_ST_RUN;
      end
      crc_pkg::CRC_ST_RUN: begin
        if (pdown_req) state_nxt = crc_pkg::CRC_ST_PDOWN;
        else if (idle_req) state_nxt = crc_pkg::CRC_ST_IDLE;
      end
      crc_pkg::CRC_ST_IDLE: begin
        if (rst_level_r || wake_event) state_nxt = crc_pkg::CRC_ST_RUN;
      end
      crc_pkg::CRC_ST_PDOWN: begin
        if (rst_level_r || wake_event) state_nxt = crc_pkg::CRC_ST_RUN;
      end
      default: begin
        state_nxt = crc_pkg::CRC_ST_RESET;
      end
    endcase
    if (chip_reset_r) state_nxt = crc_pkg::CRC_ST_RESET;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) state_r <= crc_pkg::CRC_ST_RESET;
    else state_r <= state_nxt;
  end

  // ==========================================================================
  // Oscillator clock gates
  wire in_pdown = (state_r == crc_pkg::CRC_ST_PDOWN);
  wire in_idle  = (state_r == crc_pkg::CRC_ST_IDLE);
  wire ref_on   = ~in_pdown;
  wire cpu_on   = ~in_pdown & ~in_idle;
  wire per_on   = ~in_pdown;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pll_ref_clk_en <= 1'b0;
      cpu_clk_en     <= 1'b0;
      per_clk_en     <= 1'b0;
    end else begin
      pll_ref_clk_en <= ref_on;
      cpu_clk_en     <= cpu_on;
      per_clk_en     <= per_on;
    end
  end

  // Timers, card, SPI and port sampling all draw on the peripheral clock
  genvar gi;
  generate
    for (gi = 0; gi < crc_pkg::NUM_PER; gi++) begin : g_per
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) per_tick[gi] <= 1'b0;
        else per_tick[gi] <= per_on & per_consumer_on[gi];
      end
    end
  endgenerate

  // ==========================================================================
  // PLL dividers
  logic [DIV_W-1:0] n_cnt_r;
  logic [DIV_W-1:0] r_cnt_r;
  logic             vco_prev_r;

  wire pll_active = pll_run_enable & ~chip_reset_r;
  wire vco_rise   = vco_level_r & ~vco_prev_r;

  // A divide value of zero behaves as one
  wire [DIV_W:0] n_inc = {1'b0, n_cnt_r} + {{DIV_W{1'b0}}, 1'b1};
  wire [DIV_W:0] r_inc = {1'b0, r_cnt_r} + {{DIV_W{1'b0}}, 1'b1};
  wire n_hit = pll_active & pll_ref_clk_en & (n_inc >= {1'b0, pll_n_div});
  wire r_hit = pll_active & vco_rise & (r_inc >= {1'b0, pll_r_div});

  wire [DIV_W-1:0] n_cnt_nxt =
    (!pll_active || n_hit) ? '0 : pll_ref_clk_en ? n_inc[DIV_W-1:0] : n_cnt_r;
  wire [DIV_W-1:0] r_cnt_nxt =
    (!pll_active || r_hit) ? '0 : vco_rise ? r_inc[DIV_W-1:0] : r_cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      n_cnt_r    <= '0;
      r_cnt_r    <= '0;
      vco_prev_r <= 1'b0;
    end else begin
      n_cnt_r    <= n_cnt_nxt;
      r_cnt_r    <= r_cnt_nxt;
      vco_prev_r <= vco_level_r;
    end
  end

  // ==========================================================================
  // Phase comparator and lock detector
  crc_pll_if pll_bus ();

  assign pll_bus.ref_tick = n_hit;
  assign pll_bus.fb_tick  = r_hit;
  assign pll_bus.enable   = pll_active;

  crc_pfd u_pfd (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pll     (pll_bus.pfd)
  );

  assign charge_up   = pll_bus.up;
  assign charge_down = pll_bus.down;

  // ==========================================================================
  // PLL clock enables
  // Held off until lock so a hunting VCO never reaches downstream logic
  wire pll_gate_open = pll_active & pll_bus.locked;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) pll_locked <= 1'b0;
    else pll_locked <= pll_bus.locked;
  end

  generate
    for (gi = 0; gi < crc_pkg::NUM_PLL_OUT; gi++) begin : g_pll
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) pll_tick[gi] <= 1'b0;
        else pll_tick[gi] <= pll_gate_open & vco_rise;
      end
    end
  endgenerate

endmodule : crc_top

// ==== crc_top_sva.sv ====
// Port assertions for the clock and reset controller.
// Assumes a bind into crc_top; one clock domain.
`timescale 1ns/1ps
module crc_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Inputs watched
  input wire logic       rst_pin_in,
  input wire logic       idle_req,
  input wire logic       pdown_req,
  input wire logic [4:0] per_consumer_on,
  input wire logic       pll_run_enable,
  // Outputs watched
  input wire logic       charge_up,
  input wire logic       charge_down,
  input wire logic       chip_reset_n_out,
  input wire logic       port_reset_force,
  input wire logic       pll_ref_clk_en,
  input wire logic       cpu_clk_en,
  input wire logic       per_clk_en,
  input wire logic [4:0] per_tick,
  input wire logic [2:0] pll_tick,
  input wire logic       pll_locked
);
  // ==========================================================================
  // Run lengths of the raw pin, saturating
  logic [7:0] hi_cnt_r;
  logic [7:0] lo_cnt_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt_r <= 8'h00;
      lo_cnt_r <= 8'h00;
    end else begin
      hi_cnt_r <= rst_pin_in ? hi_cnt_r + {7'h0, hi_cnt_r != 8'hff} : 8'h00;
      lo_cnt_r <= rst_pin_in ? 8'h00 : lo_cnt_r + {7'h0, lo_cnt_r != 8'hff};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Properties
  property p_force; port_reset_force == (rst_pin_in || !chip_reset_n_out); endproperty
  a_force: assert property (p_force) else $error("port force wrong");
  property p_qual_min; $fell(chip_reset_n_out) |-> hi_cnt_r >= 8'h40; endproperty
  a_qual_min: assert property (p_qual_min) else $error("reset too early");
  property p_qual_max; hi_cnt_r == 8'h48 |-> !chip_reset_n_out; endproperty
  a_qual_max: assert property (p_qual_max) else $error("reset missing");
  property p_restart; lo_cnt_r >= 8'h08 |-> chip_reset_n_out; endproperty
  a_restart: assert property (p_restart) else $error("reset not released");
  property p_idle; $fell(cpu_clk_en) |-> $past(idle_req, 2) || $past(pdown_req, 2); endproperty
  a_idle: assert property (p_idle) else $error("cpu gate fell alone");
  property p_order; pll_ref_clk_en == per_clk_en && (per_clk_en || !cpu_clk_en); endproperty
  a_order: assert property (p_order) else $error("gate mix wrong");
  property p_wake; hi_cnt_r >= 8'h08 |-> cpu_clk_en && per_clk_en; endproperty
  a_wake: assert property (p_wake) else $error("pin did not wake");
  property p_per; per_tick != 5'h00 |-> (per_tick & ~$past(per_consumer_on)) == 5'h00; endproperty
  a_per: assert property (p_per) else $error("consumer tick unasked");
  property p_pump; !(charge_up && charge_down); endproperty
  a_pump: assert property (p_pump) else $error("pump both ways");
  // Lock status is registered once more than the pump, so it clears one edge later
  property p_off; !pll_run_enable [*3] |-> !pll_locked && pll_tick == 3'h0 && !charge_up; endproperty
  a_off: assert property (p_off) else $error("pll active while off");
  property p_gate; pll_tick != 3'h0 |-> pll_locked; endproperty
  a_gate: assert property (p_gate) else $error("pll tick unlocked");
  c_chip: cover property ($fell(chip_reset_n_out));
  c_idle: cover property ($fell(cpu_clk_en) && per_clk_en);
  c_lock: cover property ($rose(pll_locked));
endmodule : crc_chk

bind crc_top crc_chk crc_chk_inst (.clk_sys, .reset_n, .rst_pin_in, .idle_req, .pdown_req, .per_consumer_on,
  .pll_run_enable, .charge_up, .charge_down, .chip_reset_n_out, .port_reset_force, .pll_ref_clk_en,
  .cpu_clk_en, .per_clk_en, .per_tick, .pll_tick, .pll_locked);

// ==== crc_top_tb.sv ====
// Self-checking testbench for the clock and reset controller.
// Assumes crc_board stands in for the reset circuit and VCO.
`timescale 1ns/1ps
module crc_top_tb;
  logic       clk_sys, reset_n, press, tmode, idle_req, pdown_req, wake_event, pll_en;
  logic [4:0] per_on, per_tick;
  logic [7:0] n_div, r_div;
  logic       rst_pin, vco, up, dn, chip_rst_n, force_o, tm_act, ref_en, cpu_en, per_en, locked;
  logic [2:0] pll_tick;
  int         n_mismatch, n_checks;

  crc_top crc_top_inst (.clk_sys, .reset_n, .rst_pin_in(rst_pin), .test_mode_input(tmode), .idle_req,
    .pdown_req, .wake_event, .per_consumer_on(per_on), .pll_run_enable(pll_en), .pll_n_div(n_div),
    .pll_r_div(r_div), .vco_clk_in(vco), .charge_up(up), .charge_down(dn), .chip_reset_n_out(chip_rst_n),
    .port_reset_force(force_o), .test_mode_active(tm_act), .pll_ref_clk_en(ref_en), .cpu_clk_en(cpu_en),
    .per_clk_en(per_en), .per_tick, .pll_tick, .pll_locked(locked));
  crc_board crc_board_inst (.press, .run(pll_en), .up, .dn, .rst_pin, .vco);

  always #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // ==========================================================================
  // Scenarios
  task automatic t_basic();
    check("run gates", {4'h0, ref_en, cpu_en, per_en, chip_rst_n}, 8'h0f);
    check("no force", {7'h0, force_o}, 8'h00);
    tmode = 1'b0;
    tick(6);
    check("test mode", {7'h0, tm_act}, 8'h01);
    tmode = 1'b1;
    tick(6);
    $display("t_basic done");
  endtask : t_basic
  task automatic t_rst();
    press = 1'b1;
    tick(40);
    press = 1'b0;
    tick(10);
    check("short pulse", {7'h0, chip_rst_n}, 8'h01);
    press = 1'b1;
    tick(2);
    check("force on pin", {7'h0, force_o}, 8'h01);
    tick(58);
    check("not yet", {7'h0, chip_rst_n}, 8'h01);
    tick(12);
    check("qualified", {6'h0, chip_rst_n, force_o}, 8'h01);
    press = 1'b0;
    tick(10);
    check("released", {6'h0, chip_rst_n, force_o}, 8'h02);
    $display("t_rst done");
  endtask : t_rst
  task automatic t_power();
    idle_req = 1'b1;
    tick(1);
    idle_req = 1'b0;
    tick(1);
    check("idle gates", {5'h0, ref_en, cpu_en, per_en}, 8'h05);
    wake_event = 1'b1;
    tick(1);
    wake_event = 1'b0;
    tick(1);
    check("wake gates", {5'h0, ref_en, cpu_en, per_en}, 8'h07);
    idle_req = 1'b1;
    pdown_req = 1'b1;
    tick(1);
    idle_req = 1'b0;
    pdown_req = 1'b0;
    tick(2);
    check("pdown gates", {5'h0, ref_en, cpu_en, per_en}, 8'h00);
    check("pdown ticks", {3'h0, per_tick}, 8'h00);
    press = 1'b1;
    tick(8);
    press = 1'b0;
    check("pin wake", {4'h0, ref_en, cpu_en, per_en, chip_rst_n}, 8'h0f);
    tick(10);
    $display("t_power done");
  endtask : t_power
  task automatic t_per();
    for (int i = 0; i < 6; i++) begin
      per_on = (i == 5) ? 5'h1f : 5'h01 << i;
      tick(1);
      check("consumer tick", {3'h0, per_tick}, {3'h0, per_on});
    end
    $display("t_per done");
  endtask : t_per
  task automatic t_pll();
    int k;
    int ups;
    int tks;
    k = 0;
    ups = 0;
    tks = 0;
    check("pll idle", {4'h0, locked, pll_tick}, 8'h00);
    // Reference 16 x 10 ns matches two nominal 80 ns board VCO periods
    n_div = 8'h10;
    r_div = 8'h02;
    pll_en = 1'b1;
    repeat (24) begin
      tick(1);
      ups += up | dn;
    end
    check("pump pulse", 8'(ups != 0), 8'h01);
    while (k < 4000 && locked !== 1'b1) begin
      tick(1);
      k++;
    end
    check("lock", {7'h0, locked}, 8'h01);
    if (locked !== 1'b1) final_report();
    // Board VCO period lies between 64 and 96 ns: 8 to 13 rises in 800 ns
    repeat (80) begin
      tick(1);
      tks += (pll_tick == 3'h7);
    end
    check("pll ticks", 8'(tks >= 8 && tks <= 13), 8'h01);
    pll_en = 1'b0;
    tick(2);
    check("pll off", {4'h0, locked, up, dn, |pll_tick}, 8'h00);
    $display("t_pll done");
  endtask : t_pll

  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    {press, idle_req, pdown_req, wake_event, pll_en} = 5'h00;
    tmode = 1'b1;
    per_on = 5'h1f;
    n_div = 8'h01;
    r_div = 8'h01;
    tick(16);
    reset_n = 1'b1;
    tick(4);
    t_basic();
    t_rst();
    t_power();
    t_per();
    t_pll();
    final_report();
  end
endmodule : crc_top_tb
